// ### include/i2c_mem_pkg.sv
// shared constants and types for the serial memory slave
package i2c_mem_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // memory geometry
  localparam int WORD_W = 8;
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_DEPTH = 256;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // slave address byte layout
  localparam int TYPE_HI = 7;
  localparam int TYPE_LO = 4;
  localparam int SEL_HI = 3;
  localparam int SEL_LO = 2;
  localparam int SEL_W = 2;
  localparam int PAGE_BIT = 1;
  localparam int RW_BIT = 0;
  localparam logic [3:0] DEVICE_TYPE = 4'hA;
  localparam logic RW_READ = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // bit counter positions within one byte frame
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [CNT_W-1:0] ACK_BIT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // link side state machine
  typedef enum logic [4:0] {
    st_addr = 5'b00001,
    st_word = 5'b00010,
    st_write = 5'b00100,
    st_read = 5'b01000,
    st_ignore = 5'b10000
  } link_state_type;

endpackage : i2c_mem_pkg

// ### src/byte_memory.sv
// byte wide storage array with registered read port
module byte_memory #(
  parameter int ADDR_W = 9,
  parameter int WORD_W = 8,
  parameter int DEPTH = 512
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data
);

  logic [WORD_W-1:0] mem [DEPTH];

  // write port, one byte per edge
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, old data on a same address collision
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : byte_memory

// ### src/i2c_mem_slave.sv
// two wire serial memory slave: condition detection, byte engine, storage
module i2c_mem_slave
  import i2c_mem_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [i2c_mem_pkg::SEL_W-1:0] device_select_pins,
  input wire logic write_protect,
  output logic bus_busy,
  output logic device_selected
);

  import i2c_mem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // system clock side: bus condition detection

  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic start_evt;
  logic stop_evt;
  logic in_frame_reg;
  logic in_frame_next;
  logic link_rst_reg;
  logic sel_meta_reg;
  logic sel_sync_reg;

  // two stage synchronisers for both bus lines, idle level high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_clk;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // data edges while clock stays high
  assign start_evt = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_evt = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  // frame level: open at start, closed at stop
  always_comb begin
    in_frame_next = in_frame_reg;
    if (start_evt) begin
      in_frame_next = 1'b1;
    end else if (stop_evt) begin
      in_frame_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= in_frame_next;
    end
  end

  // link reset: held outside frames, pulsed on every start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_rst_reg <= 1'b1;
    end else begin
      link_rst_reg <= start_evt | ~in_frame_next;
    end
  end

  assign bus_busy = in_frame_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link clock side: pin straps

  logic [SEL_W-1:0] pins_meta_reg;
  logic [SEL_W-1:0] pins_sync_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;

  // straps resynchronised on the bus clock; open pins are pulled low in the pad
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
    end else begin
      pins_meta_reg <= device_select_pins;
      pins_sync_reg <= pins_meta_reg;
      wp_meta_reg <= write_protect;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock side: receive engine on rising clock

  link_state_type state_reg;
  link_state_type state_next;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [WORD_W-1:0] rx_shreg;
  logic [WORD_W-1:0] byte_in;
  logic ack_reg;
  logic ack_next;
  logic hit_reg;
  logic hit_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] addr_inc;
  logic last_bit;
  logic ack_slot;
  logic addr_hit;
  logic wr_en;
  logic [WORD_W-1:0] rd_data;

  // byte as it completes on the eighth rising edge, msb first
  assign byte_in = {rx_shreg[WORD_W-2:0], sda_in};
  assign last_bit = (bit_cnt_reg == LAST_BIT);
  assign ack_slot = (bit_cnt_reg == ACK_BIT);
  assign addr_inc = addr_reg + 9'h001;

  // type nibble fixed, select bits against the strapped pins
  assign addr_hit = (byte_in[TYPE_HI:TYPE_LO] == DEVICE_TYPE)
                    && (byte_in[SEL_HI:SEL_LO] == pins_sync_reg);

  // storage write on the eighth bit, before the acknowledge goes out
  assign wr_en = last_bit && (state_reg == st_write) && !wp_sync_reg;

  // next state, acknowledge request and address update
  always_comb begin
    state_next = state_reg;
    ack_next = ack_reg;
    hit_next = hit_reg;
    addr_next = addr_reg;
    if (last_bit) begin
      ack_next = 1'b0;
      unique case (state_reg)
        st_addr: begin
          if (addr_hit) begin
            ack_next = 1'b1;
            hit_next = 1'b1;
            addr_next[ADDR_W-1] = byte_in[PAGE_BIT];
            if (byte_in[RW_BIT] == RW_READ) begin
              state_next = st_read;
            end else begin
              state_next = st_word;
            end
          end else begin
            state_next = st_ignore;
          end
        end
        st_word: begin
          ack_next = 1'b1;
          addr_next[WORD_W-1:0] = byte_in;
          state_next = st_write;
        end
        st_write: begin
          if (wp_sync_reg) begin
            state_next = st_ignore;
          end else begin
            ack_next = 1'b1;
            addr_next = addr_inc;
          end
        end
        st_read: begin
          addr_next = addr_inc;
        end
        st_ignore: begin
          state_next = st_ignore;
        end
      endcase
    end else if (ack_slot) begin
      ack_next = 1'b0;
      if ((state_reg == st_read) && sda_in) begin
        state_next = st_ignore;
      end
    end
  end

  // bit counter, shifter, state and acknowledge request
  always_ff @(posedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      state_reg <= st_addr;
      bit_cnt_reg <= CNT_RESET;
      rx_shreg <= '0;
      ack_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      hit_reg <= hit_next;
      if (ack_slot) begin
        bit_cnt_reg <= CNT_RESET;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        rx_shreg <= byte_in;
      end
    end
  end

  // address latch survives start and stop, cleared only at power-on
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= ADDR_RESET;
    end else begin
      addr_reg <= addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // read port follows the address latch every rising edge
  byte_memory #(
    .ADDR_W(ADDR_W),
    .WORD_W(WORD_W),
    .DEPTH(MEM_DEPTH)
  ) u_storage (
    .clk(scl_clk),
    .wr_en(wr_en),
    .wr_addr(addr_reg),
    .wr_data(byte_in),
    .rd_addr(addr_reg),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link clock side: transmit engine on falling clock

  logic sda_oe_reg;
  logic [WORD_W-1:0] tx_shreg;

  // pull low for acknowledge or a zero data bit, release otherwise
  always_ff @(negedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      sda_oe_reg <= 1'b0;
      tx_shreg <= '0;
    end else if (ack_slot && ack_reg) begin
      sda_oe_reg <= 1'b1;
    end else if ((state_reg == st_read) && (bit_cnt_reg == CNT_RESET)) begin
      sda_oe_reg <= ~rd_data[WORD_W-1];
      tx_shreg <= {rd_data[WORD_W-2:0], 1'b0};
    end else if ((state_reg == st_read) && !ack_slot) begin
      sda_oe_reg <= ~tx_shreg[WORD_W-1];
      tx_shreg <= {tx_shreg[WORD_W-2:0], 1'b0};
    end else begin
      sda_oe_reg <= 1'b0;
    end
  end

  // open drain: output level is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // selection status back into the system clock domain

  // level crossing, first stage read by the second only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_meta_reg <= 1'b0;
      sel_sync_reg <= 1'b0;
    end else begin
      sel_meta_reg <= hit_reg;
      sel_sync_reg <= sel_meta_reg;
    end
  end

  assign device_selected = sel_sync_reg;

endmodule : i2c_mem_slave

// ### bench/mem_slave_asserts.sv
// concurrent checks on the serial memory slave ports
module mem_slave_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic bus_busy,
  input wire logic device_selected
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_q, scl_q;
  logic [3:0] stop_age;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // bus lines one clock back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_q <= 1'h1;
      scl_q <= 1'h1;
    end else begin
      sda_q <= sda_in;
      scl_q <= scl_clk;
    end
  end

  // clocks since the last stop pattern, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_age <= 4'hF;
    end else if (scl_q & scl_clk & ~sda_q & sda_in) begin
      stop_age <= 4'h0;
    end else begin
      stop_age <= stop_age + {3'h0, stop_age != 4'hF};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl_clk && sda_in ##1 scl_clk && !sda_in;
  endsequence
  sequence s_stop;
    scl_clk && !sda_in ##1 scl_clk && sda_in;
  endsequence
  sequence s_quiet;
    !bus_busy [*3];
  endsequence

  a_drain_only: assert property (sda_out == 1'h0)
    else $error("data line driven high");
  a_idle_release: assert property (s_quiet |-> !sda_oe)
    else $error("data pulled outside a frame");
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_clk && bus_busy)
    else $error("data pull began with clock high");
  a_oe_steady: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
    else $error("data pull moved while clock high");
  a_start_busy: assert property (s_start |-> ##[1:6] bus_busy)
    else $error("start not seen");
  a_stop_idle: assert property (s_stop |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  a_busy_fall: assert property ($fell(bus_busy) |-> stop_age < 4'h7)
    else $error("busy dropped without stop");
  a_sel_clear: assert property (s_start or s_stop |-> ##[1:10] !device_selected)
    else $error("selection survived a condition");
  a_sel_in_frame: assert property ($rose(device_selected) |-> bus_busy)
    else $error("selected outside a frame");
  a_ack_selected: assert property ($rose(sda_oe) |-> ##[0:6] device_selected)
    else $error("pull without selection");
endmodule : mem_slave_asserts

bind i2c_mem_slave mem_slave_asserts u_chk (.clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy), .device_selected(device_selected));

// ### bench/i2c_master_model.sv
// bus master model driving the serial clock and its data pull
module i2c_master_model (
  output logic scl_clk,
  output logic m_oe,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: clock high, data released
  initial begin
    scl_clk = 1'h1;
    m_oe = 1'h0;
  end

  // one bit: data set mid low, taken mid high
  task automatic bit_io(input logic b, output logic r);
    #20;
    m_oe = ~b;
    #20;
    scl_clk = 1'h1;
    #20;
    r = sda_in;
    #20;
    scl_clk = 1'h0;
  endtask : bit_io

  // data falls with clock high, long hold
  task automatic start();
    m_oe = 1'h0;
    #20;
    scl_clk = 1'h1;
    #60;
    m_oe = 1'h1;
    #100;
    scl_clk = 1'h0;
  endtask : start

  // master owns data, rises with clock high
  task automatic stop();
    #20;
    m_oe = 1'h1;
    #20;
    scl_clk = 1'h1;
    #100;
    m_oe = 1'h0;
    #100;
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask : send

  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : recv
endmodule : i2c_master_model

// ### bench/tb.sv
// self-checking bench for the serial memory slave
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_mem_pkg::*;

  typedef struct packed {logic [1:0] p; logic [1:0] s; logic w; logic [8:0] a; logic [7:0] d;} row_type;
  // pins, address select, protect, address, data
  row_type rows [5] = '{'{2'h0, 2'h0, 1'h0, 9'h005, 8'h3C}, '{2'h2, 2'h2, 1'h0, 9'h1FF, 8'hA5},
    '{2'h3, 2'h1, 1'h0, 9'h010, 8'h99}, '{2'h1, 2'h1, 1'h1, 9'h1FF, 8'h11}, '{2'h1, 2'h1, 1'h0, 9'h0FF, 8'h5A}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] pins = 2'h0;
  logic wp = 1'h0;
  logic scl_clk, m_oe, sda_out, sda_oe, bus_busy, device_selected, k, k2;
  logic [7:0] d;
  logic [7:0] mm [MEM_DEPTH];
  int n_fail = 0;
  int tests_run = 0;
  // wired-AND data line with pull-up
  wire logic sda_in = ~m_oe & ~(sda_oe & ~sda_out);

  always #10 clk = ~clk;

  i2c_mem_slave u_dut (.clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_pins(pins), .write_protect(wp), .bus_busy(bus_busy),
    .device_selected(device_selected));
  i2c_master_model u_m (.scl_clk(scl_clk), .m_oe(m_oe), .sda_in(sda_in));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  function automatic logic [7:0] slv(input logic [1:0] s, input logic pg, input logic rw);
    return {DEVICE_TYPE, s, pg, rw};
  endfunction : slv

  // load the address, repeated start, read one byte
  task automatic rd(input logic [1:0] s, input logic [8:0] a, output logic [7:0] q);
    logic ak;
    u_m.start();
    u_m.send(slv(s, a[8], 1'h0), ak);
    u_m.send(a[7:0], ak);
    u_m.start();
    u_m.send(slv(s, a[8], RW_READ), ak);
    u_m.recv(1'h0, q);
    u_m.stop();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    #5;
    check("idle", 8'h00, {bus_busy, device_selected, sda_oe});
    foreach (rows[i]) begin
      @(posedge clk);
      pins <= rows[i].p;
      wp <= rows[i].w;
      @(posedge clk);
      #5;
      u_m.start();
      u_m.send(slv(rows[i].s, rows[i].a[8], 1'h0), k);
      check("busy", 8'h01, bus_busy);
      check("addr_ack", rows[i].p == rows[i].s, k);
      check("selected", rows[i].p == rows[i].s, device_selected);
      if (k) begin
        u_m.send(rows[i].a[7:0], k);
        u_m.send(rows[i].d, k2);
        check("data_ack", !rows[i].w, k2);
        if (!rows[i].w) mm[rows[i].a] = rows[i].d;
      end
      u_m.stop();
      if (rows[i].p == rows[i].s) begin
        rd(rows[i].s, rows[i].a, d);
        check("rdata", mm[rows[i].a], d);
      end
    end
    // burst write over the top address
    u_m.start();
    u_m.send(slv(2'h1, 1'h1, 1'h0), k);
    u_m.send(8'hFF, k);
    u_m.send(8'h77, k);
    u_m.send(8'h88, k2);
    u_m.stop();
    check("wrap_ack", 8'h01, k2);
    rd(2'h1, 9'h000, d);
    check("wrap_low", 8'h88, d);
    rd(2'h1, 9'h1FF, d);
    check("wrap_top", 8'h77, d);
    // current address read follows the wrapped latch
    u_m.start();
    u_m.send(slv(2'h1, 1'h0, RW_READ), k);
    u_m.recv(1'h0, d);
    u_m.stop();
    check("next_read", 8'h88, d);
    // write cut short by start, then by stop
    for (int j = 0; j < 2; j++) begin
      u_m.start();
      u_m.send(slv(2'h1, 1'h0, 1'h0), k);
      u_m.send(8'h05, k);
      repeat (4) u_m.bit_io(1'h1, k);
      if (j == 1) u_m.stop();
      rd(2'h1, 9'h005, d);
      check("abort", 8'h3C, d);
    end
    // sequential read across the top address, master acks the first byte
    u_m.start();
    u_m.send(slv(2'h1, 1'h1, 1'h0), k);
    u_m.send(8'hFF, k);
    u_m.start();
    u_m.send(slv(2'h1, 1'h1, RW_READ), k);
    u_m.recv(1'h1, d);
    check("seq_top", 8'h77, d);
    u_m.recv(1'h0, d);
    check("seq_wrap", 8'h88, d);
    u_m.stop();
    // protected byte leaves the address latch where it was
    @(posedge clk);
    wp <= 1'h1;
    @(posedge clk);
    #5;
    u_m.start();
    u_m.send(slv(2'h1, 1'h1, 1'h0), k);
    u_m.send(8'hFF, k);
    u_m.send(8'h12, k2);
    u_m.stop();
    check("wp_nack", 8'h00, k2);
    u_m.start();
    u_m.send(slv(2'h1, 1'h1, RW_READ), k);
    u_m.recv(1'h0, d);
    u_m.stop();
    check("wp_hold", 8'h77, d);
    // power-on reset in mid-frame: idle outputs, address latch back to zero
    u_m.start();
    u_m.send(slv(2'h1, 1'h0, 1'h0), k);
    u_m.send(8'h05, k);
    @(posedge clk);
    rst <= 1'h1;
    wp <= 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    #5;
    check("reset_idle", 8'h00, {bus_busy, device_selected, sda_oe});
    u_m.stop();
    u_m.start();
    u_m.send(slv(2'h1, 1'h0, RW_READ), k);
    u_m.recv(1'h0, d);
    u_m.stop();
    check("reset_addr", 8'h88, d);
    print_verdict();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule : tb
